/* File: design/timer_irq_pkg.sv */
package timer_irq_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [4:0] OFS_IRQ_ENABLE_CH0  = 5'h00;
  localparam logic [4:0] OFS_IRQ_ENABLE_CH1  = 5'h04;
  localparam logic [4:0] OFS_IRQ_ENABLE_CH2  = 5'h08;
  localparam logic [4:0] OFS_EVENT_FLAGS_CH0 = 5'h0C;
  localparam logic [4:0] OFS_EVENT_FLAGS_CH1 = 5'h10;
  localparam logic [4:0] OFS_EVENT_FLAGS_CH2 = 5'h14;
  localparam logic [4:0] OFS_IRQ_STATUS      = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK        = 5'h1C;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0] RST_IRQ_ENABLE  = 8'h40;
  localparam logic [7:0] RST_EVENT_FLAGS = 8'hC0;
  localparam logic [2:0] RST_IRQ_STATUS  = 3'h0;
  localparam logic [2:0] RST_IRQ_MASK    = 3'h0;

  // ==========================================================
  // field positions, shared by enable and flag registers
  // ==========================================================
  localparam int BIT_MATCH_A   = 0;
  localparam int BIT_MATCH_B   = 1;
  localparam int BIT_MATCH_C   = 2;
  localparam int BIT_MATCH_D   = 3;
  localparam int BIT_OVERFLOW  = 4;
  localparam int BIT_UNDERFLOW = 5;
  localparam int BIT_FIXED_ONE = 6;
  localparam int BIT_TOP       = 7;  // adc_trigger_enable / count_direction_flag

  // ==========================================================
  // implemented bit masks per channel
  // ==========================================================
  localparam logic [7:0] ENABLE_MASK_CH0 = 8'h9F;
  localparam logic [7:0] ENABLE_MASK_CH12 = 8'hB3;
  localparam logic [5:0] FLAG_MASK_CH0   = 6'h1F;
  localparam logic [5:0] FLAG_MASK_CH12  = 6'h33;

  // events from the counter / compare datapath, one set per channel
  typedef struct packed {
    logic phase_mode;   // level: channel in phase counting mode
    logic count_up;     // level: counter direction, 1 = up
    logic underflow;    // pulse: wrap minimum to maximum
    logic overflow;     // pulse: wrap maximum to zero
    logic match_d;      // pulse: compare match or capture on register d
    logic match_c;
    logic match_b;
    logic match_a;
  } chan_events_s;

  // activation from the data transfer controller, per channel
  typedef struct packed {
    logic [3:0] act;          // pulse per source d..a
    logic       transfer_irq_disable_select;        // transfer_irq_disable_select
    logic       count_nz;     // transfer count not zero
  } dtc_ack_s;

  // interrupt requests toward the interrupt controller
  typedef struct packed {
    logic underflow_irq;
    logic overflow_irq;
    logic match_d_irq;
    logic match_c_irq;
    logic match_b_irq;
    logic match_a_irq;
  } irq_req_s;

endpackage

/* File: design/timer_channel_irq_status.sv */
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module timer_channel_irq_status #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                nrst,
  input  wire logic                                hw_standby,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]                   avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [31:0]                         avs_writedata,
  input  wire logic [3:0]                          avs_byteenable,
  output logic      [31:0]                         avs_readdata,
  output logic                                     avs_waitrequest,
  // timer datapath events
  input  wire timer_irq_pkg::chan_events_s [2:0]   chan_ev,
  // data transfer controller activation
  input  wire timer_irq_pkg::dtc_ack_s [2:0]       dtc_ack,
  // requests out
  output timer_irq_pkg::irq_req_s [2:0]            irq_req,
  output logic      [2:0]                          adc_trigger,
  output logic                                     irq
);

  // ==========================================================
  // helper functions
  // ==========================================================

  // writable enable bits of a channel
  function automatic logic [7:0] enable_mask(input int ch);
    enable_mask = (ch == 0) ? timer_irq_pkg::ENABLE_MASK_CH0 : timer_irq_pkg::ENABLE_MASK_CH12;
  endfunction

  // implemented event flags of a channel
  function automatic logic [5:0] flag_mask(input int ch);
    flag_mask = (ch == 0) ? timer_irq_pkg::FLAG_MASK_CH0 : timer_irq_pkg::FLAG_MASK_CH12;
  endfunction

  // decode a byte address into a word hit
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    addr_hit = (a == ADDR_W'(ofs));
  endfunction

  // ==========================================================
  // reset and bus handshake
  // ==========================================================

  // hardware standby holds the same state as a system reset
  // the bus handshake stays on nrst only, so an access in flight still completes
  logic rst;
  assign rst = !nrst || hw_standby;

  logic ack_q;
  logic req;
  logic rd_done;
  logic wr_done;
  logic wr_lane;

  assign req     = avs_read || avs_write;
  assign wr_lane = avs_byteenable[0];

  // one wait state: data is looked up on the first edge, handed over on the second
  assign avs_waitrequest = req && !ack_q;
  assign rd_done         = avs_read && ack_q;
  assign wr_done         = avs_write && ack_q && wr_lane;

  // ack toggles so back-to-back requests each get their wait state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // ==========================================================
  // register state
  // ==========================================================
  logic [2:0][7:0] ie_q;      // interrupt enables, bit 6 stored as constant
  logic [2:0][5:0] flag_q;    // event flags a..u
  logic [2:0]      dir_q;     // count direction, channels 1 and 2 use it
  logic [2:0][5:0] armed_q;   // flags seen as 1 by the last read
  logic [2:0]      sts_q;     // sticky per-channel interrupt status
  logic [2:0]      msk_q;     // mask for sts_q
  logic [2:0]      any_q;     // previous any-request level per channel
  logic [2:0]      adc_q;
  logic [31:0]     rdata_q;

  // per-register write hits and flag read hits
  logic [2:0] wr_ie;
  logic [2:0] wr_flag;
  logic [2:0] rd_flag;
  logic       wr_sts;
  logic       wr_msk;

  assign wr_ie[0]   = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_ENABLE_CH0);
  assign wr_ie[1]   = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_ENABLE_CH1);
  assign wr_ie[2]   = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_ENABLE_CH2);
  assign wr_flag[0] = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH0);
  assign wr_flag[1] = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH1);
  assign wr_flag[2] = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH2);
  assign rd_flag[0] = rd_done && addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH0);
  assign rd_flag[1] = rd_done && addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH1);
  assign rd_flag[2] = rd_done && addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH2);
  assign wr_sts     = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_STATUS);
  assign wr_msk     = wr_done && addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_MASK);

  // ==========================================================
  // event sources
  // ==========================================================
  logic [2:0][5:0] set_ev;
  logic [2:0][5:0] clr_ev;

  // set and clear terms of every flag, limited to the implemented bits
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      set_ev[c] = 6'h00;
      clr_ev[c] = 6'h00;
      set_ev[c][timer_irq_pkg::BIT_MATCH_A]   = chan_ev[c].match_a;
      set_ev[c][timer_irq_pkg::BIT_MATCH_B]   = chan_ev[c].match_b;
      set_ev[c][timer_irq_pkg::BIT_MATCH_C]   = chan_ev[c].match_c;
      set_ev[c][timer_irq_pkg::BIT_MATCH_D]   = chan_ev[c].match_d;
      set_ev[c][timer_irq_pkg::BIT_OVERFLOW]  = chan_ev[c].overflow;
      set_ev[c][timer_irq_pkg::BIT_UNDERFLOW] = chan_ev[c].underflow && chan_ev[c].phase_mode;
      // software clear: only a written 0 on a bit the last read showed as 1
      if (wr_flag[c]) begin
        clr_ev[c] = armed_q[c] & ~avs_writedata[5:0];
      end
      // transfer controller activation with select low and count not zero clears the compare flag that started it
      if (!dtc_ack[c].transfer_irq_disable_select && dtc_ack[c].count_nz) begin
        clr_ev[c][3:0] = clr_ev[c][3:0] | dtc_ack[c].act;
      end
      set_ev[c] = set_ev[c] & flag_mask(c);
      clr_ev[c] = clr_ev[c] & flag_mask(c);
    end
  end

  // ==========================================================
  // interrupt enable registers
  // ==========================================================

  // reserved bits never store a value, so a stray write cannot turn them on
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (rst) begin
        ie_q[c] <= timer_irq_pkg::RST_IRQ_ENABLE;
      end else if (wr_ie[c]) begin
        ie_q[c] <= (avs_writedata[7:0] & enable_mask(c)) | timer_irq_pkg::RST_IRQ_ENABLE;
      end
    end
  end

  // ==========================================================
  // event flag registers
  // ==========================================================

  // set wins over clear so an event landing on a clear is never lost
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (rst) begin
        flag_q[c] <= timer_irq_pkg::RST_EVENT_FLAGS[5:0];
      end else begin
        flag_q[c] <= ((flag_q[c] & ~clr_ev[c]) | set_ev[c]) & flag_mask(c);
      end
    end
  end

  // arming: remember what software saw; a write to the register with byte lane 0 enabled disarms it
  // an event landing between the read and the write is not armed, so it survives
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (rst) begin
        armed_q[c] <= 6'h00;
      end else if (rd_flag[c]) begin
        armed_q[c] <= rdata_q[5:0] & flag_mask(c);
      end else if (wr_flag[c]) begin
        armed_q[c] <= 6'h00;
      end
    end
  end

  // direction follows the counter only in phase counting mode on channels 1 and 2, else it counts up
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (rst) begin
        dir_q[c] <= timer_irq_pkg::RST_EVENT_FLAGS[timer_irq_pkg::BIT_TOP];
      end else if (c == 0) begin
        dir_q[c] <= 1'b1;
      end else begin
        dir_q[c] <= chan_ev[c].phase_mode ? chan_ev[c].count_up : 1'b1;
      end
    end
  end

  // ==========================================================
  // requests toward interrupt controller and converter
  // ==========================================================

  // levels: high while flag and enable are both set
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      irq_req[c].match_a_irq   = flag_q[c][timer_irq_pkg::BIT_MATCH_A] && ie_q[c][timer_irq_pkg::BIT_MATCH_A];
      irq_req[c].match_b_irq   = flag_q[c][timer_irq_pkg::BIT_MATCH_B] && ie_q[c][timer_irq_pkg::BIT_MATCH_B];
      irq_req[c].match_c_irq   = flag_q[c][timer_irq_pkg::BIT_MATCH_C] && ie_q[c][timer_irq_pkg::BIT_MATCH_C];
      irq_req[c].match_d_irq   = flag_q[c][timer_irq_pkg::BIT_MATCH_D] && ie_q[c][timer_irq_pkg::BIT_MATCH_D];
      irq_req[c].overflow_irq  = flag_q[c][timer_irq_pkg::BIT_OVERFLOW] && ie_q[c][timer_irq_pkg::BIT_OVERFLOW];
      irq_req[c].underflow_irq = flag_q[c][timer_irq_pkg::BIT_UNDERFLOW] && ie_q[c][timer_irq_pkg::BIT_UNDERFLOW];
    end
  end

  // converter start: one-cycle pulse per register-a event, registered
  // registering costs one cycle of latency but keeps the trigger free of glitches
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (rst) begin
        adc_q[c] <= 1'b0;
      end else begin
        adc_q[c] <= chan_ev[c].match_a && ie_q[c][timer_irq_pkg::BIT_TOP];
      end
    end
  end

  assign adc_trigger = adc_q;

  // ==========================================================
  // summary interrupt: sticky status, mask, one level output
  // ==========================================================
  logic [2:0] any_req;

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      any_req[c] = |irq_req[c];
    end
  end

  // a channel event is the rise of its combined request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      any_q <= 3'h0;
    end else begin
      any_q <= any_req;
    end
  end

  // write one to clear; a new rise in the same cycle keeps the bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sts_q <= timer_irq_pkg::RST_IRQ_STATUS;
    end else begin
      sts_q <= (sts_q & ~(wr_sts ? avs_writedata[2:0] : 3'h0)) | (any_req & ~any_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msk_q <= timer_irq_pkg::RST_IRQ_MASK;
    end else if (wr_msk) begin
      msk_q <= avs_writedata[2:0];
    end
  end

  assign irq = |(sts_q & msk_q);

  // ==========================================================
  // read data
  // ==========================================================
  logic [31:0] rd_mux;

  // flag register bit 6 is forced here, not stored; enable registers read back their fixed bits from ie_q
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_ENABLE_CH0): rd_mux[7:0] = ie_q[0];
      addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_ENABLE_CH1): rd_mux[7:0] = ie_q[1];
      addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_ENABLE_CH2): rd_mux[7:0] = ie_q[2];
      addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH0): rd_mux[7:0] = {dir_q[0], 1'b1, flag_q[0]};
      addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH1): rd_mux[7:0] = {dir_q[1], 1'b1, flag_q[1]};
      addr_hit(avs_address, timer_irq_pkg::OFS_EVENT_FLAGS_CH2): rd_mux[7:0] = {dir_q[2], 1'b1, flag_q[2]};
      addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_STATUS):      rd_mux[2:0] = sts_q;
      addr_hit(avs_address, timer_irq_pkg::OFS_IRQ_MASK):        rd_mux[2:0] = msk_q;
      default:                                                    rd_mux = 32'h0000_0000;
    endcase
  end

  // captured on the wait-state edge, held through the handover edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata = rdata_q;

endmodule

`default_nettype wire

/* File: verification/timer_irq_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks for the interrupt enable and event flag block
module timer_irq_chk #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic                             sys_clk,
  input wire logic                             nrst,
  input wire logic                             hw_standby,
  // register bus
  input wire logic [ADDR_W-1:0]                avs_address,
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic [31:0]                      avs_readdata,
  input wire logic                             avs_waitrequest,
  // datapath events, controller answers and requests
  input wire timer_irq_pkg::chan_events_s [2:0] chan_ev,
  input wire timer_irq_pkg::dtc_ack_s [2:0]     dtc_ack,
  input wire timer_irq_pkg::irq_req_s [2:0]     irq_req,
  input wire logic [2:0]                       adc_trigger,
  input wire logic                             irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst || hw_standby);
  logic [2:0] ma_q;
  logic       en0_wr_q;
  logic       rd_ok;
  // causes one cycle back, since trigger and flags are registered
  always_ff @(posedge sys_clk) begin
    ma_q     <= {chan_ev[2].match_a, chan_ev[1].match_a, chan_ev[0].match_a};
    en0_wr_q <= avs_write && avs_address == timer_irq_pkg::OFS_IRQ_ENABLE_CH0;
  end
  // a read answer is taken where waitrequest is low
  assign rd_ok = avs_read && !avs_waitrequest;
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one wait state");
  a_fixed_one: assert property (
    rd_ok && avs_address < timer_irq_pkg::OFS_IRQ_STATUS && avs_address[1:0] == 2'b00 |-> avs_readdata[6])
    else $error("bit 6 read as zero");
  a_ch0_bit_five: assert property (rd_ok && (avs_address == timer_irq_pkg::OFS_IRQ_ENABLE_CH0 ||
    avs_address == timer_irq_pkg::OFS_EVENT_FLAGS_CH0) |-> !avs_readdata[5])
    else $error("channel 0 bit 5 read as one");
  a_ch0_dir_one: assert property (rd_ok && avs_address == timer_irq_pkg::OFS_EVENT_FLAGS_CH0
    |-> avs_readdata[7]) else $error("channel 0 bit 7 read as zero");
  a_ch12_no_cd: assert property (rd_ok && avs_address[4:2] inside {3'h1, 3'h2, 3'h4, 3'h5}
    |-> avs_readdata[3:2] == 2'b00) else $error("channel 1 or 2 bits 3..2 not zero");
  a_trig_cause: assert property ((adc_trigger & ~ma_q) == 3'h0)
    else $error("converter trigger without match a");
  a_ovf_cause: assert property ($rose(irq_req[0].overflow_irq) |-> $past(chan_ev[0].overflow) ||
    $past(avs_write)) else $error("overflow request without cause");
  a_write_no_set: assert property ($rose(irq_req[0].match_a_irq) |-> $past(chan_ev[0].match_a) ||
    en0_wr_q) else $error("match a request raised by a write");
  a_flag_sticky: assert property (irq_req[0].match_b_irq && !avs_write && !dtc_ack[0].act[1]
    |=> irq_req[0].match_b_irq) else $error("match b request dropped by itself");
  a_dtc_clear: assert property (dtc_ack[0].act[0] && !dtc_ack[0].transfer_irq_disable_select && dtc_ack[0].count_nz &&
    !chan_ev[0].match_a |=> !irq_req[0].match_a_irq) else $error("activation left flag a set");
  a_ufl_mode: assert property (chan_ev[1].underflow && !chan_ev[1].phase_mode && !avs_write &&
    !irq_req[1].underflow_irq |=> !irq_req[1].underflow_irq) else $error("underflow outside phase mode");
  a_absent_irq: assert property (!irq_req[0].underflow_irq && !irq_req[1].match_d_irq &&
    !irq_req[1].match_c_irq && !irq_req[2].match_d_irq && !irq_req[2].match_c_irq)
    else $error("request from a missing flag");
  c_trigger: cover property (|adc_trigger);
  c_dtc: cover property (dtc_ack[0].act[0] && irq_req[0].match_a_irq);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: verification/dtc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// transfer controller stand-in, answers match a requests only
module dtc_model (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // set-up from the bench
  input  wire logic [2:0]                    en,
  input  wire logic                          transfer_irq_disable_select,
  input  wire logic [3:0]                    lat,
  input  wire logic [7:0]                    count_init,
  // device side
  input  wire timer_irq_pkg::irq_req_s [2:0] irq_req,
  output timer_irq_pkg::dtc_ack_s [2:0]      dtc_ack
);
  logic [2:0] prev_q;
  logic [2:0] act_q;
  logic [3:0] wait_q [3];
  logic [7:0] cnt_q;
  // one activation per rising request, lat cycles later, prompt or slow
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      prev_q[c] <= irq_req[c].match_a_irq;
      act_q[c]  <= 1'b0;
      if (!nrst) begin
        wait_q[c] <= 4'h0;
      end else if (irq_req[c].match_a_irq && !prev_q[c] && en[c]) begin
        wait_q[c] <= lat;
      end else if (wait_q[c] != 4'h0) begin
        wait_q[c] <= wait_q[c] - 4'h1;
        act_q[c]  <= (wait_q[c] == 4'h1);
      end
    end
  end
  // one count shared by all channels, a simplification of the real controller
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q <= count_init;
    end else if (|act_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // clearing asked only with select low and count left
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      dtc_ack[c] = {3'h0, act_q[c], transfer_irq_disable_select, cnt_q != 8'h00};
    end
  end
endmodule
`default_nettype wire

/* File: verification/timer_channel_irq_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// self-checking bench with a register model
module timer_channel_irq_status_test;
  localparam logic [4:0] EA [3] = '{5'h00, 5'h04, 5'h08};
  localparam logic [4:0] FA [3] = '{5'h0C, 5'h10, 5'h14};
  logic                              sys_clk = 1'b0;
  logic                              nrst = 1'b0;
  logic                              hw_standby = 1'b0;
  logic [4:0]                        avs_address = 5'h00;
  logic                              avs_read = 1'b0;
  logic                              avs_write = 1'b0;
  logic [31:0]                       avs_writedata = 32'h0;
  logic [3:0]                        avs_byteenable = 4'hF;
  logic [31:0]                       avs_readdata;
  logic                              avs_waitrequest;
  timer_irq_pkg::chan_events_s [2:0] chan_ev = '0;
  timer_irq_pkg::dtc_ack_s [2:0]     dtc_ack;
  timer_irq_pkg::irq_req_s [2:0]     irq_req;
  logic [2:0]                        adc_trigger;
  logic                              irq;
  logic [2:0]                        den = 3'h0;
  logic                              transfer_irq_disable_select = 1'b0;
  logic [3:0]                        lat = 4'h1;
  logic [7:0]                        en [3];
  logic [5:0]                        fl [3];
  logic [5:0]                        arm [3];
  logic [2:0]                        st, mk, po;
  logic [31:0]                       rnd = 32'h6917;
  int                                err_total = 0;
  int                                compares = 0;
  // clock, 4 ns period
  always #2 sys_clk = ~sys_clk;
  // design and the transfer controller model
  timer_channel_irq_status #(.ADDR_W(5)) DUT (.sys_clk(sys_clk), .nrst(nrst), .hw_standby(hw_standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .chan_ev(chan_ev), .dtc_ack(dtc_ack), .irq_req(irq_req), .adc_trigger(adc_trigger), .irq(irq));
  dtc_model u_dtc (.sys_clk(sys_clk), .nrst(nrst), .en(den), .transfer_irq_disable_select(transfer_irq_disable_select), .lat(lat),
    .count_init(8'h02), .irq_req(irq_req), .dtc_ack(dtc_ack));
  // model helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [4:0] a);
    exp_rd = 8'h00;
    for (int c = 0; c < 3; c++) begin
      if (a == EA[c]) exp_rd = en[c] | 8'h40;
      if (a == FA[c]) exp_rd = {(c == 0 || !chan_ev[c].phase_mode) | chan_ev[c].count_up, 1'b1, fl[c]};
    end
    if (a == timer_irq_pkg::OFS_IRQ_STATUS) exp_rd = {5'h00, st};
    if (a == timer_irq_pkg::OFS_IRQ_MASK) exp_rd = {5'h00, mk};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // status bit follows a rise of the channel's combined request
  task automatic upd();
    logic n;
    for (int c = 0; c < 3; c++) begin
      n = |(fl[c] & en[c][5:0]);
      if (n && !po[c]) st[c] = 1'b1;
      po[c] = n;
    end
  endtask
  // one bus transfer; the request stands until waitrequest is seen low
  task automatic acc(input logic [4:0] a, input logic w, input logic [7:0] d);
    logic wl;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    // no local limit: a wait that never ends is caught by the watchdog
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    // a write with lane 0 off is answered but changes nothing
    wl = w && avs_byteenable[0];
    if (!w) chk(exp_rd(a), avs_readdata[7:0]);
    if (!w) chk(8'h00, {7'h0, |avs_readdata[31:8]});
    for (int c = 0; c < 3; c++) begin
      if (!w && a == FA[c]) arm[c] = fl[c];
      if (wl && a == EA[c]) en[c] = d & (c == 0 ? 8'h9F : 8'hB3);
      if (wl && a == FA[c]) fl[c] = fl[c] & ~(arm[c] & ~d[5:0]);
      if (wl && a == FA[c]) arm[c] = 6'h00;
    end
    if (wl && a == timer_irq_pkg::OFS_IRQ_STATUS) st = st & ~d[2:0];
    if (wl && a == timer_irq_pkg::OFS_IRQ_MASK) mk = d[2:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
    upd();
  endtask
  // event pulse with new direction and mode levels
  task automatic ev(input int c, input logic [7:0] r);
    chan_ev[c] <= r;
    @(posedge sys_clk);
    chan_ev[c][5:0] <= 6'h00;
    @(posedge sys_clk);
    chk({7'h0, r[0] & en[c][7]}, {7'h0, adc_trigger[c]});
    fl[c] = fl[c] | (r[5:0] & (c == 0 ? 6'h1F : 6'h33) & (r[7] ? 6'h3F : 6'h1F));
    upd();
  endtask
  task automatic cmp_out();
    @(posedge sys_clk);
    for (int c = 0; c < 3; c++) chk({2'h0, fl[c] & en[c][5:0]}, {2'h0, irq_req[c]});
    chk({7'h0, |(st & mk)}, {7'h0, irq});
  endtask
  task automatic rst_run(input logic sb);
    if (sb) hw_standby <= 1'b1;
    else nrst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    hw_standby <= 1'b0;
    nrst <= 1'b1;
    for (int c = 0; c < 3; c++) {en[c], fl[c], arm[c]} = 20'h0;
    {st, mk, po} = 9'h0;
    @(posedge sys_clk);
  endtask
  task automatic chk_all();
    for (int i = 0; i < 8; i++) acc(5'(i * 4), 1'b0, 8'h00);
    acc(5'h02, 1'b0, 8'h00);
  endtask
  task automatic stop_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
  // main sequence
  initial begin
    int c;
    rst_run(1'b0);
    chk_all();
    $display("test reset_values done");
    for (int k = 0; k < 3; k++) acc(EA[k], 1'b1, 8'hFF);
    for (int k = 0; k < 3; k++) acc(FA[k], 1'b1, 8'hFF);
    chk_all();
    $display("test writable_bits done");
    for (int i = 0; i < 400; i++) begin
      rnd = lfsr(rnd);
      c = rnd[9:8] % 3;
      avs_byteenable <= {3'h7, |rnd[14:12]};
      case (rnd[2:0])
        3'h0, 3'h1: ev(c, {rnd[23] & (c != 0), rnd[22], rnd[21:16]});
        3'h2: acc(EA[c], 1'b1, rnd[31:24]);
        3'h3: acc(FA[c], 1'b0, 8'h00);
        3'h4: acc(FA[c], 1'b1, rnd[31:24]);
        3'h5: acc(timer_irq_pkg::OFS_IRQ_MASK, 1'b1, rnd[31:24]);
        3'h6: acc(timer_irq_pkg::OFS_IRQ_STATUS, 1'b1, rnd[31:24]);
        default: acc({rnd[28:26], 2'b00}, 1'b0, 8'h00);
      endcase
      cmp_out();
    end
    avs_byteenable <= 4'hF;
    $display("test random_traffic done");
    rst_run(1'b1);
    chk_all();
    $display("test standby done");
    rst_run(1'b0);
    den <= 3'h1;
    acc(EA[0], 1'b1, 8'h01);
    for (int k = 0; k < 3; k++) begin
      transfer_irq_disable_select <= (k == 0);
      lat <= 4'(1 + 5 * k);
      acc(FA[0], 1'b0, 8'h00);
      acc(FA[0], 1'b1, 8'h00);
      ev(0, 8'h01);
      repeat (20) @(posedge sys_clk);
      if (k == 1) fl[0][0] = 1'b0;
      upd();
      acc(FA[0], 1'b0, 8'h00);
    end
    $display("test transfer_clear done");
    stop_test();
  end
endmodule
bind timer_channel_irq_status timer_irq_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .hw_standby(hw_standby), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_ev(chan_ev), .dtc_ack(dtc_ack),
  .irq_req(irq_req), .adc_trigger(adc_trigger), .irq(irq));
`default_nettype wire
